// [rtl/sdc_regs.sv]
/*
  sdc_regs: configuration, transfer-control and argument registers
  of a memory-card host, with the byte counter of the data path.
  assumes: classic wishbone master on clk_i; card clock arrives on a
  pin and is sampled here; serial protocol and fifos sit outside.
*/
`timescale 1ns/10ps
module sdc_regs
  import sdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic irq_o,
  // card link clock pin
  input wire logic card_clk_i,
  // steering outputs to the rest of the host
  output logic media_enable_o,
  output logic four_lane_o,
  output logic [1:0] tx_word_width_o,
  output logic [1:0] rx_word_width_o,
  output logic [3:0] block_exp_o,
  output logic card_write_o,
  output logic data_active_o,
  output logic cmd_start_o,
  output logic [5:0] cmd_index_o,
  output logic [31:0] cmd_argument_o
);
  // ==========================================================
  // link clock edge detection
  // ==========================================================
  logic card_rise; // one-cycle pulse per card clock rising edge

  sdc_edge_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(card_clk_i),
    .level_o(),
    .rise_o(card_rise)
  );

  // ==========================================================
  // state
  // ==========================================================
  logic [31:0] cfg_reg, cfg_next; // media_config
  logic [15:0] count_reg, count_next; // bytes left
  logic ena_reg, ena_next;
  logic dir_reg, dir_next;
  logic [31:0] arg_reg, arg_next;
  logic [5:0] idx_reg, idx_next;
  logic start_reg, start_next; // command start pulse
  logic [SDC_IRQ_W-1:0] stat_reg, stat_next;
  logic [SDC_IRQ_W-1:0] mask_reg, mask_next;
  logic irq_reg, irq_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  sdc_state_t st_reg, st_next;
  logic [3:0] edge_reg, edge_next; // card edges within one byte
  logic [15:0] blk_left_reg, blk_left_next; // bytes left in block
  logic active_reg, active_next;
  logic four_reg, four_next; // lane code 01 decoded, kept as a flop

  // ==========================================================
  // helpers
  // ==========================================================
  logic wr_req; // write taken this cycle
  logic rd_req;
  logic [31:0] wmask; // byte lanes as bit mask
  logic [15:0] blk_bytes; // block length in bytes
  logic [3:0] edges_per_byte;
  logic byte_done;
  logic done_evt;
  logic block_evt;

  always_comb begin
    wr_req = cyc_i & stb_i & we_i & ~ack_reg;
    rd_req = cyc_i & stb_i & ~we_i & ~ack_reg;
    wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    // code 0 is reserved; treated as 2**0 so the counter still moves
    blk_bytes = 16'h0001 << cfg_reg[SDC_CFG_BLK_LSB +: 4];
    // four lanes move a byte in two clocks, one lane in eight
    if (cfg_reg[SDC_CFG_LANE_LSB +: 2] == SDC_LANE_FOUR) begin
      edges_per_byte = SDC_EDGES_FOUR;
    end else begin
      edges_per_byte = SDC_EDGES_ONE;
    end
  end

  // ==========================================================
  // data path: counts card clock edges into bytes and blocks
  // ==========================================================
  always_comb begin
    st_next = st_reg;
    edge_next = edge_reg;
    blk_left_next = blk_left_reg;
    count_next = count_reg;
    active_next = 1'b0;
    byte_done = 1'b0;
    done_evt = 1'b0;
    block_evt = 1'b0;
    case (st_reg)
      SDC_IDLE: begin
        // a command write launches the data phase if one is set up
        if (start_reg && ena_reg && count_reg != 16'h0000) begin
          st_next = SDC_ARMED;
        end
      end
      SDC_ARMED: begin
        // first block loaded from the current block length
        blk_left_next = blk_bytes;
        edge_next = 4'h0;
        st_next = SDC_MOVE;
      end
      SDC_MOVE: begin
        active_next = 1'b1;
        // card edges only counted while both enables are high
        if (ena_reg && cfg_reg[SDC_CFG_EN_BIT] && card_rise) begin
          if (edge_reg == edges_per_byte - 4'h1) begin
            edge_next = 4'h0;
            byte_done = 1'b1;
          end else begin
            edge_next = edge_reg + 4'h1;
          end
        end
        if (byte_done) begin
          count_next = count_reg - 16'h0001;
          if (blk_left_reg == 16'h0001) begin
            block_evt = 1'b1;
            blk_left_next = blk_bytes;
          end else begin
            blk_left_next = blk_left_reg - 16'h0001;
          end
          if (count_reg == 16'h0001) begin
            done_evt = 1'b1;
            active_next = 1'b0;
            st_next = SDC_IDLE;
          end
        end
      end
      default: begin
        st_next = SDC_IDLE;
      end
    endcase
    // software write of the count overrides the counter
    if (wr_req && adr_i == SDC_OFF_TRANSFER_CONTROL) begin
      count_next = (count_reg & ~wmask[31:16]) | (dat_i[31:16] & wmask[31:16]);
    end
    // interface disabled: hold the data path idle
    if (!cfg_reg[SDC_CFG_EN_BIT]) begin
      st_next = SDC_IDLE;
      active_next = 1'b0;
    end
  end

  // ==========================================================
  // register file and bus answer
  // ==========================================================
  always_comb begin
    cfg_next = cfg_reg;
    ena_next = ena_reg;
    dir_next = dir_reg;
    arg_next = arg_reg;
    idx_next = idx_reg;
    mask_next = mask_reg;
    start_next = 1'b0;
    ack_next = (cyc_i & stb_i) & ~ack_reg; // one wait state
    rdat_next = rdat_reg;
    stat_next = stat_reg;
    // decode writes
    if (wr_req) begin
      if (adr_i == SDC_OFF_MEDIA_CONFIG) begin
        cfg_next = (cfg_reg & ~wmask) | (dat_i & wmask);
      end else if (adr_i == SDC_OFF_TRANSFER_CONTROL) begin
        if (sel_i[0]) begin
          ena_next = dat_i[SDC_TC_ENA_BIT];
          dir_next = dat_i[SDC_TC_DIR_BIT];
        end
      end else if (adr_i == SDC_OFF_COMMAND_ARGUMENT) begin
        arg_next = (arg_reg & ~wmask) | (dat_i & wmask);
      end else if (adr_i == SDC_OFF_COMMAND_INDEX) begin
        if (sel_i[0]) begin
          idx_next = dat_i[SDC_CMD_IDX_W-1:0];
          start_next = 1'b1;
        end
      end else if (adr_i == SDC_OFF_IRQ_STATUS) begin
        if (sel_i[0]) begin
          stat_next = stat_reg & ~dat_i[SDC_IRQ_W-1:0];
        end
      end else if (adr_i == SDC_OFF_IRQ_MASK) begin
        if (sel_i[0]) begin
          mask_next = dat_i[SDC_IRQ_W-1:0];
        end
      end
    end
    // reserved lane codes fall back to one lane, like the byte counter
    four_next = (cfg_next[SDC_CFG_LANE_LSB +: 2] == SDC_LANE_FOUR);
    // hardware events win over a clear in the same cycle
    if (done_evt) begin
      stat_next[SDC_IRQ_DONE_BIT] = 1'b1;
    end
    if (block_evt) begin
      stat_next[SDC_IRQ_BLOCK_BIT] = 1'b1;
    end
    // decode reads; reserved bits and unmapped addresses give zero
    if (rd_req) begin
      if (adr_i == SDC_OFF_MEDIA_CONFIG) begin
        rdat_next = cfg_reg & 32'h0000_33ef;
      end else if (adr_i == SDC_OFF_TRANSFER_CONTROL) begin
        rdat_next = {count_reg, 14'h0000, ena_reg, dir_reg};
      end else if (adr_i == SDC_OFF_COMMAND_ARGUMENT) begin
        rdat_next = arg_reg;
      end else if (adr_i == SDC_OFF_COMMAND_INDEX) begin
        rdat_next = {26'h0000000, idx_reg};
      end else if (adr_i == SDC_OFF_IRQ_STATUS) begin
        rdat_next = {30'h00000000, stat_reg};
      end else if (adr_i == SDC_OFF_IRQ_MASK) begin
        rdat_next = {30'h00000000, mask_reg};
      end else begin
        rdat_next = SDC_UNMAPPED_DATA;
      end
    end
    irq_next = |(stat_next & mask_next);
  end

  // registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= SDC_RST_WORD;
      count_reg <= 16'h0000;
      ena_reg <= 1'b0;
      dir_reg <= 1'b0;
      arg_reg <= SDC_RST_WORD;
      idx_reg <= 6'h00;
      start_reg <= 1'b0;
      stat_reg <= '0;
      mask_reg <= '0;
      irq_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdat_reg <= SDC_RST_WORD;
      st_reg <= SDC_IDLE;
      edge_reg <= 4'h0;
      blk_left_reg <= 16'h0000;
      active_reg <= 1'b0;
      four_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      count_reg <= count_next;
      ena_reg <= ena_next;
      dir_reg <= dir_next;
      arg_reg <= arg_next;
      idx_reg <= idx_next;
      start_reg <= start_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      st_reg <= st_next;
      edge_reg <= edge_next;
      blk_left_reg <= blk_left_next;
      active_reg <= active_next;
      four_reg <= four_next;
    end
  end

  // ==========================================================
  // outputs, all from flops
  // ==========================================================
  assign dat_o = rdat_reg;
  assign ack_o = ack_reg;
  assign irq_o = irq_reg;
  assign media_enable_o = cfg_reg[SDC_CFG_EN_BIT];
  assign four_lane_o = four_reg;
  assign tx_word_width_o = cfg_reg[SDC_CFG_TXW_LSB +: 2];
  assign rx_word_width_o = cfg_reg[SDC_CFG_RXW_LSB +: 2];
  assign block_exp_o = cfg_reg[SDC_CFG_BLK_LSB +: 4];
  assign card_write_o = dir_reg;
  assign data_active_o = active_reg;
  assign cmd_start_o = start_reg;
  assign cmd_index_o = idx_reg;
  assign cmd_argument_o = arg_reg;
endmodule

// [rtl/sdc_pkg.sv]
/*
  sdc_pkg: constants shared by the memory-card host configuration,
  transfer-control and argument register bank.
  assumes: classic wishbone slave, 32-bit data, byte addresses.
*/
package sdc_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  // ==========================================================
  localparam logic [7:0] SDC_OFF_IRQ_STATUS = 8'h00; // w1c sticky events
  localparam logic [7:0] SDC_OFF_IRQ_MASK = 8'h04; // 1 = pass to irq
  localparam logic [7:0] SDC_OFF_MEDIA_CONFIG = 8'h10;
  localparam logic [7:0] SDC_OFF_TRANSFER_CONTROL = 8'h14;
  localparam logic [7:0] SDC_OFF_COMMAND_ARGUMENT = 8'h18;
  localparam logic [7:0] SDC_OFF_COMMAND_INDEX = 8'h1c;
  // ==========================================================
  // field positions
  // ==========================================================
  localparam int SDC_CFG_LANE_LSB = 12; // 2 bits
  localparam int SDC_CFG_TXW_LSB = 8; // 2 bits
  localparam int SDC_CFG_RXW_LSB = 6; // 2 bits
  localparam int SDC_CFG_EN_BIT = 5;
  localparam int SDC_CFG_BLK_LSB = 0; // 4 bits
  localparam int SDC_TC_COUNT_LSB = 16; // 16 bits
  localparam int SDC_TC_ENA_BIT = 1;
  localparam int SDC_TC_DIR_BIT = 0;
  localparam int SDC_CMD_IDX_W = 6;
  // interrupt status bit positions
  localparam int SDC_IRQ_DONE_BIT = 0; // transfer complete
  localparam int SDC_IRQ_BLOCK_BIT = 1; // one block finished
  localparam int SDC_IRQ_W = 2;
  // ==========================================================
  // reset values and encodings
  // ==========================================================
  localparam logic [31:0] SDC_RST_WORD = 32'h0000_0000;
  localparam logic [1:0] SDC_LANE_ONE = 2'h0;
  localparam logic [1:0] SDC_LANE_FOUR = 2'h1;
  localparam logic [31:0] SDC_UNMAPPED_DATA = 32'h0000_0000;
  // link clock edge counts: bits per byte on one lane or four
  localparam logic [3:0] SDC_EDGES_ONE = 4'h8;
  localparam logic [3:0] SDC_EDGES_FOUR = 4'h2;
  // data path state machine, one-hot
  typedef enum logic [2:0] {
    SDC_IDLE = 3'b001,
    SDC_ARMED = 3'b010,
    SDC_MOVE = 3'b100
  } sdc_state_t;
endpackage

// [rtl/sdc_edge_sync.sv]
/*
  sdc_edge_sync: two-flop synchroniser for a pin plus rising-edge pulse.
  assumes: input is asynchronous to clk_i; output pulse one cycle long.
*/
`timescale 1ns/10ps
module sdc_edge_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o
);
  // ==========================================================
  // synchroniser
  // ==========================================================
  logic meta_reg; // first flop, read only by sync_reg
  logic sync_reg; // safe copy
  logic last_reg; // previous safe copy, for edge finding
  logic rise_reg;
  logic rise_next;

  // edge only from the clean copies, never the metastable flop
  always_comb begin
    rise_next = sync_reg & ~last_reg;
  end

  // registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
      rise_reg <= rise_next;
    end
  end

  assign level_o = sync_reg;
  assign rise_o = rise_reg;
endmodule

// [verif/sdc_regs_monitor.sv]
/*
  sdc_regs_monitor: port assertions for the register bank.
  assumes: bound to sdc_regs; one clock, synchronous reset.
*/
`timescale 1ns/10ps
module sdc_regs_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic irq_o,
  input wire logic media_enable_o,
  input wire logic [3:0] block_exp_o,
  input wire logic data_active_o,
  input wire logic cmd_start_o,
  input wire logic [31:0] cmd_argument_o
);
  // ==========================================================
  // helpers
  // ==========================================================
  default clocking mon_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // request waiting to be taken
  wire logic req = cyc_i && stb_i && !ack_o;
  // index write, the only thing allowed to launch a command
  wire logic cmd_wr = req && we_i && adr_i == 8'h1c && sel_i[0];
  // ==========================================================
  // assertions
  // ==========================================================
  chk_ack_next: assert property (req |=> ack_o)
    else $error("ack late");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held");
  chk_ack_cause: assert property (ack_o |-> $past(req))
    else $error("ack without request");
  chk_cmd_launch: assert property (cmd_wr |-> ##[1:2] cmd_start_o)
    else $error("command not started");
  chk_start_pulse: assert property (cmd_start_o |=> !cmd_start_o)
    else $error("start held");
  chk_idle_off: assert property (!media_enable_o ##1 !media_enable_o
    |-> !data_active_o) else $error("active while disabled");
  chk_active_cause: assert property ($rose(data_active_o)
    |-> $past(cmd_start_o) || $past(cmd_start_o, 2)
    || $past(cmd_start_o, 3)) else $error("active without command");
  chk_irq_clear: assert property ($fell(irq_o)
    |-> ack_o || $past(ack_o)) else $error("irq dropped alone");
  chk_regs_hold: assert property (!ack_o |-> $stable(block_exp_o)
    && $stable(cmd_argument_o) && $stable(media_enable_o))
    else $error("register moved without access");
  chk_read_hold: assert property (!ack_o |-> $stable(dat_o))
    else $error("read data moved");
  // main scenarios reached
  cov_active: cover property ($rose(data_active_o));
  cov_irq: cover property ($rose(irq_o));
  cov_start: cover property (cmd_start_o);
endmodule

// [verif/sdc_card_model.sv]
/*
  sdc_card_model: card side clock source for the bench.
  assumes: run_i from the bench; clock parked low between frames.
*/
`timescale 1ns/10ps
module sdc_card_model (
  input wire logic run_i,
  output logic card_clk_o
);
  // 800 ns period, phase unrelated to the system clock
  initial card_clk_o = 1'b0;
  always begin
    wait (run_i);
    #370 card_clk_o = 1'b1;
    #400 card_clk_o = 1'b0;
    #30;
  end
endmodule

// [verif/sdc_regs_tb_top.sv]
/*
  sdc_regs_tb_top: self-checking bench for the register bank.
  assumes: sdc_pkg, sdc_regs, card model and monitor compiled.
*/
`timescale 1ns/10ps
module sdc_regs_tb_top;
  import sdc_pkg::*;
  // ==========================================================
  // signals and instances
  // ==========================================================
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, card_run = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hf;
  logic [3:0] wsel = 4'hf; // byte lanes for the next access
  logic [31:0] dat_i = 32'h0, dat_o, cmd_argument_o;
  logic ack_o, irq_o, card_clk_i, media_enable_o, four_lane_o;
  logic card_write_o, data_active_o, cmd_start_o;
  logic [1:0] tx_word_width_o, rx_word_width_o;
  logic [3:0] block_exp_o;
  logic [5:0] cmd_index_o;
  int err_total = 0, tests_run = 0;
  // 100 ns system clock
  always #50 clk_i = ~clk_i;
  sdc_regs sdc_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
    .card_clk_i(card_clk_i), .media_enable_o(media_enable_o),
    .four_lane_o(four_lane_o), .tx_word_width_o(tx_word_width_o),
    .rx_word_width_o(rx_word_width_o), .block_exp_o(block_exp_o),
    .card_write_o(card_write_o), .data_active_o(data_active_o),
    .cmd_start_o(cmd_start_o), .cmd_index_o(cmd_index_o),
    .cmd_argument_o(cmd_argument_o));
  sdc_card_model sdc_card_model_inst (.run_i(card_run),
    .card_clk_o(card_clk_i));
  // ==========================================================
  // bus and compare tasks
  // ==========================================================
  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // classic cycle: everything held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= wsel;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1);
    // registered ack: one wait state, seen at the second edge
    check("ack wait", 32'h2, 32'(n));
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string what, input logic [7:0] a,
    input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(what, exp, q & m);
  endtask
  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_reset;
    rd("config", 8'h10, 32'hffff_ffff, 32'h0);
    rd("control", 8'h14, 32'hffff_ffff, 32'h0);
    rd("arg", 8'h18, 32'hffff_ffff, 32'h0);
    wr(8'h3c, 32'hffff_ffff);
    rd("unmapped", 8'h3c, 32'hffff_ffff, 32'h0);
  endtask
  // every width and lane code, low and top block sizes
  task automatic t_config;
    logic [31:0] w;
    for (int i = 0; i < 4; i++) begin
      w = (32'(i) << 12) | (32'(i) << 8) | (32'(3 - i) << 6)
        | 32'h20 | ((i == 0) ? 32'h1 : 32'(i * 5));
      wr(8'h10, w);
      rd("config", 8'h10, 32'hffff_ffff, w);
      check("lanes", 32'(i == 1), 32'(four_lane_o));
      check("tx width", 32'(i), 32'(tx_word_width_o));
      check("rx width", 32'(3 - i), 32'(rx_word_width_o));
      check("block", w & 32'hf, 32'(block_exp_o));
      check("enable", 32'h1, 32'(media_enable_o));
    end
  endtask
  task automatic t_arg;
    wr(8'h18, 32'ha5c3_0f96);
    wr(8'h18, 32'h5a3c_f069);
    rd("arg", 8'h18, 32'hffff_ffff, 32'h5a3c_f069);
  endtask
  // full transfer in 2-byte blocks, then the interrupt path
  task automatic t_xfer(input logic four, input logic dir,
    input logic [15:0] cnt);
    logic [31:0] q;
    wr(8'h10, (32'(four) << 12) | 32'h21);
    wr(8'h04, 32'h1);
    wr(8'h14, {cnt, 14'h0, 1'b1, dir});
    check("idle", 32'h0, 32'(data_active_o));
    wr(8'h1c, 32'h11);
    card_run <= 1'b1;
    repeat (4) @(posedge clk_i);
    check("active", 32'h1, 32'(data_active_o));
    check("dir", 32'(dir), 32'(card_write_o));
    check("index", 32'h11, 32'(cmd_index_o));
    check("arg out", 32'h5a3c_f069, cmd_argument_o);
    // half the bytes: 2 or 8 card edges each, 8 clocks per edge
    repeat (cnt * (four ? 8 : 32)) @(posedge clk_i);
    bus(1'b0, 8'h14, 32'h0, q);
    check("midway", 32'h1, 32'(q[31:16] < cnt && q[31:16] != 0));
    // no local limit: the watchdog ends a hang
    while (data_active_o !== 1'b0) begin
      @(posedge clk_i);
    end
    card_run <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd("left", 8'h14, 32'hffff_0000, 32'h0);
    check("irq done", 32'h1, 32'(irq_o));
    wr(8'h04, 32'h0);
    repeat (2) @(posedge clk_i);
    check("irq masked", 32'h0, 32'(irq_o));
    wr(8'h04, 32'h1);
    rd("block bit", 8'h00, 32'h2, 32'h2);
    wr(8'h00, 32'h3);
    repeat (2) @(posedge clk_i);
    check("irq clear", 32'h0, 32'(irq_o));
    rd("done bit", 8'h00, 32'h1, 32'h0);
  endtask
  // no start without data enable; interface disable freezes count
  task automatic t_hold;
    logic [31:0] q;
    wr(8'h10, 32'h21);
    wr(8'h14, 32'h0004_0000);
    wr(8'h1c, 32'h12);
    card_run <= 1'b1;
    repeat (100) @(posedge clk_i);
    check("no enable", 32'h0, 32'(data_active_o));
    rd("held", 8'h14, 32'hffff_0000, 32'h0004_0000);
    wr(8'h14, 32'h0004_0002);
    wr(8'h1c, 32'h12);
    repeat (80) @(posedge clk_i);
    // data enable off through byte lane 0 only, so the count stays
    wsel = 4'h1;
    wr(8'h14, 32'h0);
    bus(1'b0, 8'h14, 32'h0, q);
    repeat (150) @(posedge clk_i);
    check("paused active", 32'h1, 32'(data_active_o));
    rd("paused", 8'h14, 32'hffff_0000, q & 32'hffff_0000);
    wr(8'h14, 32'h2);
    wsel = 4'hf;
    wr(8'h10, 32'h01);
    bus(1'b0, 8'h14, 32'h0, q);
    repeat (150) @(posedge clk_i);
    check("stopped", 32'h0, 32'(data_active_o));
    rd("frozen", 8'h14, 32'hffff_0000, q & 32'hffff_0000);
    card_run <= 1'b0;
  endtask
  task automatic summarize;
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // main sequence after 3 cycles of reset
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_config();
    t_arg();
    t_xfer(1'b1, 1'b1, 16'h0004);
    t_xfer(1'b0, 1'b0, 16'h0002);
    t_hold();
    summarize();
  end
  // watchdog: run needs about 850 cycles
  initial begin
    #800000;
    err_total++;
    summarize();
  end
endmodule
bind sdc_regs sdc_regs_monitor sdc_regs_monitor_inst (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
  .irq_o(irq_o), .media_enable_o(media_enable_o),
  .block_exp_o(block_exp_o), .data_active_o(data_active_o),
  .cmd_start_o(cmd_start_o), .cmd_argument_o(cmd_argument_o));
